// >>> verilog/rwd_regs.sv
`timescale 1ns/100ps
module rwd_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    parameter int WAKE_SLOT_CYCLES = rwd_pkg::WAKE_SLOT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Two-wire control bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Fault conditions, rail 1 in the top bit
    input wire logic [rwd_pkg::RAIL_N-1:0] uv_hit,
    input wire logic [rwd_pkg::RAIL_N-1:0] ov_hit,
    input wire logic vin_ov_hit,
    input wire logic ot_hit,
    input wire logic [rwd_pkg::RAIL_N-1:0] oc_hit,
    input wire logic sw_oc_hit,
    input wire logic por_hit,
    // Wake-up sequencing, rail 1 in the top bit
    input wire logic wake_req,
    output logic [rwd_pkg::RAIL_N-1:0] rail_up,
    // Interrupt request
    output logic irq
);
    import rwd_pkg::*;

    typedef struct packed {
        rwd_i2c_e fsm;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic more;
        logic sda_oe;
        logic sda_out;
        logic [7:0] rail12;
        logic [7:0] rail34;
        logic [7:0] linreg;
        logic [7:0] uv;
        logic [7:0] ov;
        logic [7:0] events;
        logic [7:0] mask_uv;
        logic [7:0] mask_ov;
        logic [7:0] mask_oc;
        logic irq;
    } rwd_regs_s;

    rwd_regs_s st;
    rwd_regs_s next_st;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic wr_en;
    logic [7:0] wr_data;
    logic [4*RAIL_N-1:0] codes;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_read(input logic [7:0] addr, input rwd_regs_s s);
        case (addr)
            REG_UV_STAT: reg_read = s.uv;
            REG_OV_STAT: reg_read = s.ov;
            REG_RAIL12: reg_read = s.rail12;
            REG_RAIL34: reg_read = s.rail34;
            REG_LINREG: reg_read = s.linreg;
            REG_EVENTS: reg_read = s.events;
            REG_MASK_UV: reg_read = s.mask_uv;
            REG_MASK_OV: reg_read = s.mask_ov;
            REG_MASK_OC: reg_read = s.mask_oc;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Unmasked flag summary
    // ------------------------------------------------------------
    function automatic logic irq_pending(input rwd_regs_s s);
        irq_pending = |((s.uv & ~s.mask_uv) | (s.ov & ~s.mask_ov) | (s.events & ~s.mask_oc));
    endfunction

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    assign scl_rise = scl && !st.scl_q;
    assign scl_fall = !scl && st.scl_q;
    assign start_seen = scl && st.scl_q && st.sda_q && !sda_in;
    assign stop_seen = scl && st.scl_q && !st.sda_q && sda_in;
    assign wr_en = (st.fsm == RWD_WDATA) && scl_fall && (st.cnt == BYTE_BITS);
    assign wr_data = st.shift;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.scl_q = scl;
        next_st.sda_q = sda_in;
        next_st.sda_out = 1'b0;
        if (start_seen) begin
            next_st.fsm = RWD_ADDR;
            next_st.cnt = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_st.fsm = RWD_IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            case (st.fsm)
                RWD_IDLE: begin
                    next_st.sda_oe = 1'b0;
                end
                RWD_ADDR, RWD_PTR, RWD_WDATA: begin
                    if (scl_rise) begin
                        next_st.shift = {st.shift[6:0], sda_in};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall && st.cnt == BYTE_BITS) begin
                        next_st.cnt = 4'h0;
                        if (st.fsm == RWD_ADDR) begin
                            if (st.shift[7:1] == DEV_ADDR) begin
                                next_st.rw = st.shift[0];
                                next_st.sda_oe = 1'b1;
                                next_st.fsm = RWD_ADDR_ACK;
                            end else begin
                                next_st.fsm = RWD_IDLE;
                            end
                        end else if (st.fsm == RWD_PTR) begin
                            next_st.ptr = st.shift;
                            next_st.sda_oe = 1'b1;
                            next_st.fsm = RWD_PTR_ACK;
                        end else begin
                            next_st.ptr = st.ptr + 8'h01;
                            next_st.sda_oe = 1'b1;
                            next_st.fsm = RWD_WDATA_ACK;
                        end
                    end
                end
                RWD_ADDR_ACK, RWD_PTR_ACK, RWD_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.cnt = 4'h0;
                        if (st.fsm == RWD_ADDR_ACK && st.rw) begin
                            next_st.shift = reg_read(st.ptr, st);
                            next_st.sda_oe = ~next_st.shift[7];
                            next_st.ptr = st.ptr + 8'h01;
                            next_st.fsm = RWD_RDATA;
                        end else if (st.fsm == RWD_ADDR_ACK) begin
                            next_st.fsm = RWD_PTR;
                        end else begin
                            next_st.fsm = RWD_WDATA;
                        end
                    end
                end
                RWD_RDATA: begin
                    if (scl_rise) begin
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st.cnt == BYTE_BITS) begin
                            next_st.sda_oe = 1'b0;
                            next_st.cnt = 4'h0;
                            next_st.fsm = RWD_RACK;
                        end else begin
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.sda_oe = ~st.shift[6];
                        end
                    end
                end
                RWD_RACK: begin
                    if (scl_rise) begin
                        next_st.more = ~sda_in;
                    end else if (scl_fall) begin
                        if (st.more) begin
                            next_st.shift = reg_read(st.ptr, st);
                            next_st.sda_oe = ~next_st.shift[7];
                            next_st.ptr = st.ptr + 8'h01;
                            next_st.cnt = 4'h0;
                            next_st.fsm = RWD_RDATA;
                        end else begin
                            next_st.fsm = RWD_IDLE;
                        end
                    end
                end
                default: begin
                    next_st.fsm = RWD_IDLE;
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end

        // Register writes
        if (wr_en && !start_seen && !stop_seen) begin
            case (st.ptr)
                REG_RAIL12: begin
                    next_st.rail12 = wr_data;
                end
                REG_RAIL34: begin
                    next_st.rail34 = wr_data;
                end
                REG_LINREG: begin
                    next_st.linreg = wr_data & LINREG_BITS;
                end
                REG_UV_STAT: begin
                    next_st.uv = st.uv & ~wr_data;
                end
                REG_OV_STAT: begin
                    next_st.ov = st.ov & ~wr_data;
                end
                REG_EVENTS: begin
                    next_st.events = wr_data & SEVEN_BITS;
                end
                REG_MASK_UV: begin
                    next_st.mask_uv = wr_data & FIVE_BITS;
                end
                REG_MASK_OV: begin
                    next_st.mask_ov = wr_data & SEVEN_BITS;
                end
                REG_MASK_OC: begin
                    next_st.mask_oc = wr_data & SEVEN_BITS;
                end
                default: begin
                    next_st.ptr = next_st.ptr;
                end
            endcase
        end

        // Hardware sets win over software clears
        next_st.uv = next_st.uv | {uv_hit, 3'b000};
        next_st.ov = next_st.ov | {ov_hit, vin_ov_hit, ot_hit, 1'b0};
        next_st.events = next_st.events | {oc_hit, 3'b000};
        next_st.events[2] = next_st.events[2] | sw_oc_hit;
        next_st.events[1] = next_st.events[1] | por_hit;
        next_st.irq = irq_pending(next_st);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
            st.fsm <= RWD_IDLE;
            st.scl_q <= 1'b1;
            st.sda_q <= 1'b1;
            st.rail12 <= RAIL12_RST;
            st.rail34 <= RAIL34_RST;
            st.linreg <= LINREG_RST;
            st.uv <= FLAG_RST;
            st.ov <= FLAG_RST;
            st.events <= FLAG_RST;
            st.mask_uv <= MASK_RST;
            st.mask_ov <= MASK_RST;
            st.mask_oc <= MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign sda_out = st.sda_out;
    assign sda_oe = st.sda_oe;
    assign irq = st.irq;

    // ------------------------------------------------------------
    // Wake-up timers
    // ------------------------------------------------------------
    assign codes = {st.rail12, st.rail34, st.linreg[7:4]};

    rwd_wake_if wake_bus [RAIL_N] ();

    generate
        for (genvar i = 0; i < RAIL_N; i++) begin : g_rail
            assign wake_bus[i].wake = wake_req;
            assign wake_bus[i].code = codes[4*(RAIL_N-1-i) +: 4];
            assign rail_up[RAIL_N-1-i] = wake_bus[i].up;
            rwd_wake_timer #(
                .BASE_CYC(WAKE_BASE_CYC),
                .SLOT_CYC(WAKE_SLOT_CYCLES)
            ) u_timer (
                .clock(clock),
                .sys_rst(sys_rst),
                .w(wake_bus[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_oc_event: assert property (
        @(posedge clock) disable iff (sys_rst)
        oc_hit[4] |=> st.events[7])
        else $error("rail 1 overcurrent not recorded");

    chk_switch_event: assert property (
        @(posedge clock) disable iff (sys_rst)
        sw_oc_hit |=> st.events[2])
        else $error("switch overcurrent not recorded");

    chk_por_event: assert property (
        @(posedge clock) disable iff (sys_rst)
        por_hit |=> st.events[1])
        else $error("power-on-reset event not recorded");

    chk_event_write: assert property (
        @(posedge clock) disable iff (sys_rst)
        (wr_en && st.ptr == REG_EVENTS && !oc_hit[0]) |=> st.events[3] == $past(wr_data[3]))
        else $error("event register write lost");

    chk_status_sticky: assert property (
        @(posedge clock) disable iff (sys_rst)
        (st.uv[7] && !(wr_en && st.ptr == REG_UV_STAT && wr_data[7])) |=> st.uv[7])
        else $error("sticky status bit dropped");

    chk_irq_follow: assert property (
        @(posedge clock) disable iff (sys_rst)
        st.irq == irq_pending(st))
        else $error("interrupt does not match flags");

    chk_mask_blocks: assert property (
        @(posedge clock) disable iff (sys_rst)
        (st.mask_uv[7] && st.uv == 8'h80 && st.ov == 8'h00 && st.events == 8'h00) |-> !st.irq)
        else $error("masked undervoltage raised interrupt");

    chk_reset_codes: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> (st.rail34 == RAIL34_RST && st.rail12 == RAIL12_RST
            && st.linreg == LINREG_RST))
        else $error("wake codes wrong after reset");

    chk_reset_masks: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> (st.mask_uv == 8'h00 && st.mask_ov == 8'h00 && st.mask_oc == 8'h00))
        else $error("masks not clear after reset");

    chk_irq_raise: assert property (
        @(posedge clock) disable iff (sys_rst)
        (ot_hit && !st.mask_ov[1] && !wr_en) |=> st.irq)
        else $error("unmasked over-temperature did not raise interrupt");

    chk_ot_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        (wr_en && st.ptr == REG_OV_STAT && wr_data[1] && !ot_hit) |=> !st.ov[1])
        else $error("over-temperature status not cleared by write");

endmodule

// >>> verilog/rwd_pkg.sv
package rwd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_UV_STAT = 8'h01;
    localparam logic [7:0] REG_OV_STAT = 8'h02;
    localparam logic [7:0] REG_RAIL12 = 8'h14;
    localparam logic [7:0] REG_RAIL34 = 8'h15;
    localparam logic [7:0] REG_LINREG = 8'h16;
    localparam logic [7:0] REG_EVENTS = 8'h1A;
    localparam logic [7:0] REG_MASK_UV = 8'h1B;
    localparam logic [7:0] REG_MASK_OV = 8'h1C;
    localparam logic [7:0] REG_MASK_OC = 8'h1D;

    // ------------------------------------------------------------
    // Reset values and implemented bits
    // ------------------------------------------------------------
    localparam logic [7:0] RAIL12_RST = 8'h32;
    localparam logic [7:0] RAIL34_RST = 8'h22;
    localparam logic [7:0] LINREG_RST = 8'h10;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] LINREG_BITS = 8'hF0;
    localparam logic [7:0] FIVE_BITS = 8'hF8;
    localparam logic [7:0] SEVEN_BITS = 8'hFE;

    // ------------------------------------------------------------
    // Wake-up timing
    // ------------------------------------------------------------
    localparam int RAIL_N = 5;
    localparam int CLOCK_MHZ = 10;
    localparam int WAKE_BASE_US = 150;
    localparam int WAKE_SLOT_US = 512;
    localparam int WAKE_BASE_CYC = WAKE_BASE_US * CLOCK_MHZ;
    localparam int WAKE_SLOT_CYC = WAKE_SLOT_US * CLOCK_MHZ;
    localparam int WAKE_CNT_W = 17;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // Serial bus slave states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        RWD_IDLE,
        RWD_ADDR,
        RWD_ADDR_ACK,
        RWD_PTR,
        RWD_PTR_ACK,
        RWD_WDATA,
        RWD_WDATA_ACK,
        RWD_RDATA,
        RWD_RACK
    } rwd_i2c_e;

endpackage

// >>> verilog/rwd_wake_if.sv
`timescale 1ns/100ps
interface rwd_wake_if;
    logic wake;
    logic [3:0] code;
    logic up;
    modport ctrl (output wake, output code, input up);
    modport timer (input wake, input code, output up);
endinterface

// >>> verilog/rwd_wake_timer.sv
`timescale 1ns/100ps
module rwd_wake_timer #(
    parameter int BASE_CYC = rwd_pkg::WAKE_BASE_CYC,
    parameter int SLOT_CYC = rwd_pkg::WAKE_SLOT_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Wake channel of one rail
    rwd_wake_if.timer w
);
    import rwd_pkg::*;

    typedef struct packed {
        logic [WAKE_CNT_W-1:0] count;
        logic up;
    } rwd_timer_s;

    rwd_timer_s st;
    rwd_timer_s next_st;
    logic [WAKE_CNT_W-1:0] target;

    // ------------------------------------------------------------
    // Delay counter
    // ------------------------------------------------------------
    assign target = WAKE_CNT_W'(BASE_CYC + (int'(w.code) - 1) * SLOT_CYC);

    always_comb begin
        next_st = st;
        if (!w.wake || w.code == 4'h0) begin
            next_st.count = '0;
            next_st.up = 1'b0;
        end else if (!st.up) begin
            next_st.count = st.count + 1'b1;
            next_st.up = (st.count == target - 1'b1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign w.up = st.up;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_wake_disabled: assert property (
        @(posedge clock) disable iff (sys_rst)
        (w.code == 4'h0) |=> !st.up)
        else $error("rail rose with wake code zero");

    chk_wake_moment: assert property (
        @(posedge clock) disable iff (sys_rst)
        $rose(st.up) |-> (st.count == target) && $past(w.wake))
        else $error("rail rose at the wrong cycle");

    chk_wake_drop: assert property (
        @(posedge clock) disable iff (sys_rst)
        !w.wake |=> !st.up)
        else $error("rail stayed up without wake");

endmodule

// >>> test/rwd_host_model.sv
`timescale 1ns/100ps
module rwd_host_model (
    // Clock
    input wire logic clock,
    // Two-wire bus, data released while sda_drv is high
    output logic scl,
    output logic sda_drv,
    input wire logic sda,
    // Read results and refused bytes
    output logic [7:0] rd_byte,
    output logic rd_valid,
    output logic [7:0] nacks
);
    // ------------------------------------------------------------
    // Bit and frame tasks, all changes at the falling clock edge
    // ------------------------------------------------------------
    logic [7:0] buf_q [16];
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_byte = 8'h00;
        rd_valid = 1'b0;
        nacks = 8'h00;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic put_bit(input logic b);
        sda_drv = b;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        scl = 1'b0;
        cyc(2);
    endtask
    task automatic get_bit(output logic b);
        sda_drv = 1'b1;
        cyc(2);
        scl = 1'b1;
        cyc(2);
        b = sda;
        cyc(2);
        scl = 1'b0;
        cyc(2);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        sda_drv = 1'b0;
        cyc(4);
        scl = 1'b0;
        cyc(2);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        sda_drv = 1'b1;
        cyc(4);
    endtask
    task automatic send(input logic [7:0] v, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(a);
        ok = !a;
        if (a) nacks++;
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input int n);
        logic ok;
        start();
        send({addr, 1'b0}, ok);
        if (ok) begin
            send(ptr, ok);
            for (int i = 0; i < n; i++) send(buf_q[i], ok);
        end
        stop();
    endtask
    task automatic rd(input logic [6:0] addr, input logic [7:0] ptr, input int n);
        logic ok;
        logic [7:0] v;
        start();
        send({addr, 1'b0}, ok);
        send(ptr, ok);
        start();
        send({addr, 1'b1}, ok);
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) get_bit(v[k]);
            put_bit(i == n - 1);
            rd_byte = v;
            rd_valid = 1'b1;
            cyc(1);
            rd_valid = 1'b0;
        end
        stop();
    endtask
endmodule

// >>> test/rwd_regs_tb.sv
`timescale 1ns/100ps
module rwd_regs_tb;
    import rwd_pkg::*;
    // ------------------------------------------------------------
    // Bench signals and tables
    // ------------------------------------------------------------
    localparam int SLOT = 20;
    localparam logic [6:0] ADDR = 7'h2A;
    localparam logic [7:0] RST_T [10] = '{8'h32, 8'h22, 8'h10, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] BITS_T [10] = '{8'hFF, 8'hFF, 8'hF0, 8'h00, 8'h00, 8'h00,
        8'hFE, 8'hF8, 8'hFE, 8'hFE};
    localparam int WAKE_T [5] = '{1, 0, 15, 3, 2};
    logic clock, sys_rst, scl, sda_drv, sda, sda_out, sda_oe, wake_req, irq, rd_valid;
    logic [18:0] hv;
    logic [4:0] rail_up;
    logic [7:0] rd_byte, nacks, b, keep;
    logic [7:0] exp_q [$];
    logic [7:0] fl [3];
    logic [7:0] mk [3];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    int g;
    int rise [5];
    assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
    rwd_regs #(.DEV_ADDR(ADDR), .WAKE_SLOT_CYCLES(SLOT)) i_rwd_regs (.clock(clock),
        .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .uv_hit(hv[18:14]), .ov_hit(hv[13:9]), .vin_ov_hit(hv[8]), .ot_hit(hv[7]),
        .oc_hit(hv[6:2]), .sw_oc_hit(hv[1]), .por_hit(hv[0]), .wake_req(wake_req),
        .rail_up(rail_up), .irq(irq));
    rwd_host_model i_rwd_host_model (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda(sda),
        .rd_byte(rd_byte), .rd_valid(rd_valid), .nacks(nacks));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ------------------------------------------------------------
    // Compare, verdict, watcher and time limit
    // ------------------------------------------------------------
    task automatic compare(input logic [31:0] exp, input logic [31:0] got, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: %s, got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) compare(32'h1, 32'h0, "read with nothing expected");
            else compare(exp_q.pop_front(), rd_byte, "read byte");
        end
    end
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        hv = '0;
        wake_req = 1'b0;
        fl = '{REG_UV_STAT, REG_OV_STAT, REG_EVENTS};
        mk = '{REG_MASK_UV, REG_MASK_OV, REG_MASK_OC};
        void'($urandom(32'h81d7));
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        // Reset values, holes read zero
        for (int i = 0; i < 10; i++) exp_q.push_back(RST_T[i]);
        i_rwd_host_model.rd(ADDR, REG_RAIL12, 10);
        // Random burst write, read back through implemented bits
        for (int i = 0; i < 10; i++) begin
            keep = 8'($urandom);
            i_rwd_host_model.buf_q[i] = keep;
            exp_q.push_back(keep & BITS_T[i]);
            if (i == 6) b = keep & BITS_T[i];
        end
        i_rwd_host_model.wr(ADDR, REG_RAIL12, 10);
        compare(|(b & ~keep), irq, "irq with random events");
        i_rwd_host_model.rd(ADDR, REG_RAIL12, 10);
        for (int i = 0; i < 4; i++) i_rwd_host_model.buf_q[i] = 8'h00;
        i_rwd_host_model.wr(ADDR, REG_EVENTS, 4);
        compare(0, irq, "irq with all flags clear");
        // Wrong device address is refused
        i_rwd_host_model.buf_q[0] = 8'hFF;
        i_rwd_host_model.wr(ADDR ^ 7'h01, REG_MASK_UV, 1);
        exp_q.push_back(8'h00);
        i_rwd_host_model.rd(ADDR, REG_MASK_UV, 1);
        // Every flag: set, raise, mask, clear
        for (int j = 0; j < 19; j++) begin
            g = (j < 5) ? 0 : (j < 12) ? 1 : 2;
            b = 8'h80 >> (j - ((g == 0) ? 0 : (g == 1) ? 5 : 12));
            hv = 19'h40000 >> j;
            @(negedge clock);
            hv = '0;
            repeat (2) @(negedge clock);
            compare(1, irq, "irq on new flag");
            exp_q.push_back(b);
            i_rwd_host_model.rd(ADDR, fl[g], 1);
            i_rwd_host_model.buf_q[0] = b;
            i_rwd_host_model.wr(ADDR, mk[g], 1);
            compare(0, irq, "irq with flag masked");
            i_rwd_host_model.buf_q[0] = (g == 2) ? 8'h00 : b;
            i_rwd_host_model.wr(ADDR, fl[g], 1);
            i_rwd_host_model.buf_q[0] = 8'h00;
            i_rwd_host_model.wr(ADDR, mk[g], 1);
            exp_q.push_back(8'h00);
            i_rwd_host_model.rd(ADDR, fl[g], 1);
            compare(0, irq, "irq after clear");
        end
        // Wake-up delays per rail, code zero never rises
        i_rwd_host_model.buf_q[0] = 8'h10;
        i_rwd_host_model.buf_q[1] = 8'hF3;
        i_rwd_host_model.buf_q[2] = 8'h20;
        i_rwd_host_model.wr(ADDR, REG_RAIL12, 3);
        rise = '{0, 0, 0, 0, 0};
        wake_req = 1'b1;
        for (int n = 1; n <= 1900; n++) begin
            @(posedge clock);
            #1;
            for (int i = 0; i < 5; i++) if (rail_up[4 - i] === 1'b1 && rise[i] == 0) rise[i] = n;
        end
        for (int i = 0; i < 5; i++) begin
            compare((WAKE_T[i] == 0) ? 0 : 1500 + (WAKE_T[i] - 1) * SLOT, rise[i], "wake");
        end
        @(negedge clock);
        wake_req = 1'b0;
        repeat (2) @(negedge clock);
        compare(0, rail_up, "rails after wake drop");
        compare(1, nacks, "refused bytes");
        compare(0, exp_q.size(), "reads outstanding");
        summarize();
    end
endmodule
